/* File: hw/spscr_regs.vh */
// Purpose: register indices, field positions, reset values for the spi unit
// Assumes: included by hw/spscr_core.v only
// Notes:   byte address of a register is four times its index
`ifndef SPSCR_REGS_VH
`define SPSCR_REGS_VH

// ============================================================
// register indices
`define SPSCR_IDX_STATUS   8'hC4
`define SPSCR_IDX_DATA     8'hC5
`define SPSCR_IDX_CTRL     8'hC6
`define SPSCR_IDX_AUX      8'hC7

// ============================================================
// serial_control_reg fields
`define SPSCR_CTL_RATE0    0
`define SPSCR_CTL_RATE1    1
`define SPSCR_CTL_CLOCK_SAMPLE_EDGE     2
`define SPSCR_CTL_CLOCK_IDLE_LEVEL     3
`define SPSCR_CTL_MASTER_SELECT     4
`define SPSCR_CTL_SLAVE_SELECT_IGNORE     5
`define SPSCR_CTL_EN       6
`define SPSCR_CTL_RATE2    7

// ============================================================
// auxiliary control fields
`define SPSCR_AUX_UIE      0
`define SPSCR_AUX_ENH      1

// ============================================================
// serial_status_reg fields
`define SPSCR_ST_TC        7
`define SPSCR_ST_WRITE_COLLISION_FLAG      6
`define SPSCR_ST_SLAVE_SELECT_ERROR_FLAG     5
`define SPSCR_ST_MODE_FAULT_FLAG      4
`define SPSCR_ST_TXE       3
`define SPSCR_ST_ORD       2
`define SPSCR_ST_REMAP     1
`define SPSCR_ST_TX_BUFFER_IRQ_ENABLE      0

// ============================================================
// reset values and timing
`define SPSCR_RST_STATUS   8'h00
`define SPSCR_RST_DATA     8'h00
`define SPSCR_RST_CTRL     8'h00
`define SPSCR_RST_AUX      2'h0
`define SPSCR_RST_PINS     4'hF
`define SPSCR_RATE_TIMER   3'h7
`define SPSCR_LAST_EDGE    5'h0F
`define SPSCR_END_PHASE    5'h10
`define SPSCR_LAST_BIT     4'h7

`endif

/* File: hw/spscr_core.v */
// Purpose: spi unit with clock-rate select, data register, status register
// Assumes: classic wishbone slave, one 50 MHz clock, synchronous reset
// Notes:   pins pass a three-flop filter; eight bits per transfer
`timescale 1ns/1ps
`include "spscr_regs.vh"

module spscr_core
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [31:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        timer1_ovf_i,
  input  wire [3:0]  p1_i,
  output reg  [3:0]  p1_o,
  output reg  [3:0]  p1_oe_o,
  output reg         irq_o
);

  // ============================================================
  // register state
  reg  [7:0] ctrl_ff;
  reg  [1:0] aux_ff;
  reg        tc_ff;
  reg        write_collision_flag_ff;
  reg        slave_select_error_flag_ff;
  reg        mode_fault_flag_ff;
  reg        txe_ff;
  reg  [2:0] cfg_ff;
  reg  [7:0] txbuf_ff;
  reg        txfull_ff;
  reg  [7:0] rxdata_ff;
  reg        arm_ff;

  // ============================================================
  // engine state
  reg  [7:0] tx_ff;
  reg  [7:0] rx_ff;
  reg  [3:0] bitcnt_ff;
  reg        mbusy_ff;
  reg  [4:0] phase_ff;
  reg  [6:0] div_ff;
  reg        sck_ff;
  reg        sckprev_ff;

  // ============================================================
  // pin filter state
  reg  [3:0] s1_ff;
  reg  [3:0] s2_ff;
  reg  [3:0] s3_ff;
  reg  [3:0] pin_ff;

  wire       en    = ctrl_ff[`SPSCR_CTL_EN];
  wire       master_select  = ctrl_ff[`SPSCR_CTL_MASTER_SELECT];
  wire       slave_select_ignore  = ctrl_ff[`SPSCR_CTL_SLAVE_SELECT_IGNORE];
  wire       clock_idle_level  = ctrl_ff[`SPSCR_CTL_CLOCK_IDLE_LEVEL];
  wire       clock_sample_edge  = ctrl_ff[`SPSCR_CTL_CLOCK_SAMPLE_EDGE];
  wire [2:0] rate  = {ctrl_ff[`SPSCR_CTL_RATE2],
                      ctrl_ff[`SPSCR_CTL_RATE1],
                      ctrl_ff[`SPSCR_CTL_RATE0]};
  wire       uie   = aux_ff[`SPSCR_AUX_UIE];
  wire       enhanced_mode_bit   = aux_ff[`SPSCR_AUX_ENH];
  wire       lsbf  = cfg_ff[`SPSCR_ST_ORD];
  wire       remap = cfg_ff[`SPSCR_ST_REMAP];
  wire       tx_buffer_irq_enable  = cfg_ff[`SPSCR_ST_TX_BUFFER_IRQ_ENABLE];

  // ============================================================
  // three-flop input filter, one per pin
  wire [3:0] pin_rst = `SPSCR_RST_PINS;
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pin_sync
      // value moves only once the second and third stage agree
      always @(posedge clk_i)
      begin
        if (rst_i)
        begin
          s1_ff[g]  <= pin_rst[g];
          s2_ff[g]  <= pin_rst[g];
          s3_ff[g]  <= pin_rst[g];
          pin_ff[g] <= pin_rst[g];
        end
        else
        begin
          s1_ff[g] <= p1_i[g];
          s2_ff[g] <= s1_ff[g];
          s3_ff[g] <= s2_ff[g];
          if (s2_ff[g] == s3_ff[g])
            pin_ff[g] <= s3_ff[g];
        end
      end
    end
  endgenerate

  // pin positions swap with the layout bit
  wire ss_in   = remap ? pin_ff[3] : pin_ff[0];
  wire mosi_in = remap ? pin_ff[0] : pin_ff[1];
  wire miso_in = remap ? pin_ff[1] : pin_ff[2];
  wire sck_in  = remap ? pin_ff[2] : pin_ff[3];

  // ============================================================
  // mode decode
  wire collide = en & master_select & ~slave_select_ignore & ~ss_in;
  wire slv_sel = en & ~master_select & (slave_select_ignore | ~ss_in);
  wire lead    = (sckprev_ff == clock_idle_level) & (sck_in != clock_idle_level);
  wire trail   = (sckprev_ff != clock_idle_level) & (sck_in == clock_idle_level);
  wire slv_smp = slv_sel & (clock_sample_edge ? trail : lead);
  wire slv_shf = slv_sel & (bitcnt_ff != 4'h0) & (clock_sample_edge ? lead : trail);
  wire slave_select_error_flag_ev = en & ~master_select & ~slave_select_ignore & ss_in & (bitcnt_ff != 4'h0);

  // ============================================================
  // master half-period tick from the rate code
  wire [7:0] lim_w = (8'h01 << rate) - 8'h01;
  wire       tick  = (rate == `SPSCR_RATE_TIMER) ? timer1_ovf_i
                     : (div_ff == lim_w[6:0]);
  wire       m_tick = en & master_select & mbusy_ff & tick & ~collide;
  wire       m_smp  = m_tick & (phase_ff < `SPSCR_END_PHASE)
                      & (phase_ff[0] == clock_sample_edge);
  wire       m_shf  = m_tick & (phase_ff < `SPSCR_END_PHASE)
                      & (phase_ff[0] != clock_sample_edge)
                      & ~(~clock_sample_edge & (phase_ff == `SPSCR_LAST_EDGE))
                      & ~(clock_sample_edge & (phase_ff == 5'h00));
  wire       m_done = m_tick & (phase_ff == `SPSCR_END_PHASE);
  wire       m_load = en & master_select & ~mbusy_ff & txfull_ff & ~collide;

  // ============================================================
  // combined shifter events
  wire smp      = m_smp | slv_smp;
  wire shf      = m_shf | slv_shf;
  wire s_done   = slv_smp & (bitcnt_ff == `SPSCR_LAST_BIT);
  wire s_load   = en & ~master_select & (bitcnt_ff == 4'h0) & txfull_ff & ~slv_smp;
  wire load     = m_load | s_load;
  wire done     = m_done | s_done;
  wire din      = master_select ? miso_in : mosi_in;
  wire [7:0] rx_nxt = lsbf ? {din, rx_ff[7:1]} : {rx_ff[6:0], din};
  wire [7:0] rx_fin = master_select ? rx_ff : rx_nxt;
  wire       dout   = lsbf ? tx_ff[0] : tx_ff[7];

  // ============================================================
  // shift engine
  always @(posedge clk_i)
  begin
    if (rst_i | ~en)
    begin
      tx_ff      <= `SPSCR_RST_DATA;
      rx_ff      <= `SPSCR_RST_DATA;
      bitcnt_ff  <= 4'h0;
      mbusy_ff   <= 1'b0;
      phase_ff   <= 5'h00;
      div_ff     <= 7'h00;
      sck_ff     <= 1'b0;
      sckprev_ff <= 1'b0;
    end
    else
    begin
      sckprev_ff <= sck_in;
      // divider runs only while a master byte is in flight
      if (~mbusy_ff | tick)
        div_ff <= 7'h00;
      else
        div_ff <= div_ff + 7'h01;
      if (~mbusy_ff)
        sck_ff <= clock_idle_level;
      if (m_tick & (phase_ff < `SPSCR_END_PHASE))
      begin
        sck_ff   <= ~sck_ff;
        phase_ff <= phase_ff + 5'h01;
      end
      if (smp)
      begin
        rx_ff     <= rx_nxt;
        bitcnt_ff <= bitcnt_ff + 4'h1;
      end
      if (shf)
        tx_ff <= lsbf ? {1'b0, tx_ff[7:1]} : {tx_ff[6:0], 1'b0};
      // a collision drops the master byte on the floor
      if (collide)
        mbusy_ff <= 1'b0;
      if (done)
      begin
        tx_ff     <= rx_fin;
        bitcnt_ff <= 4'h0;
        mbusy_ff  <= 1'b0;
      end
      if (slave_select_error_flag_ev)
        bitcnt_ff <= 4'h0;
      if (load)
      begin
        tx_ff    <= txbuf_ff;
        mbusy_ff <= master_select;
        phase_ff <= 5'h00;
        div_ff   <= 7'h00;
      end
    end
  end

  // ============================================================
  // pin drivers; disabled unit leaves every pin to the port
  always @*
  begin
    p1_o    = 4'h0;
    p1_oe_o = 4'h0;
    if (en & master_select & ~collide)
    begin
      p1_o[remap ? 0 : 1]    = dout;
      p1_oe_o[remap ? 0 : 1] = 1'b1;
      p1_o[remap ? 2 : 3]    = sck_ff;
      p1_oe_o[remap ? 2 : 3] = 1'b1;
    end
    else if (slv_sel)
    begin
      p1_o[remap ? 1 : 2]    = dout;
      p1_oe_o[remap ? 1 : 2] = 1'b1;
    end
  end

  // ============================================================
  // wishbone decode
  wire [31:0] a_stat = {22'h000000, `SPSCR_IDX_STATUS, 2'b00};
  wire [31:0] a_data = {22'h000000, `SPSCR_IDX_DATA, 2'b00};
  wire [31:0] a_ctrl = {22'h000000, `SPSCR_IDX_CTRL, 2'b00};
  wire [31:0] a_aux  = {22'h000000, `SPSCR_IDX_AUX, 2'b00};
  wire        req    = wb_cyc_i & wb_stb_i;
  wire        acc    = req & wb_ack_o;
  wire        wr     = acc & wb_we_i & wb_sel_i[0];
  wire        rd     = acc & ~wb_we_i;
  wire        hit_st = wb_adr_i == a_stat;
  wire        hit_dt = wb_adr_i == a_data;
  wire [7:0]  wd     = wb_dat_i[7:0];
  wire        st_wr  = wr & hit_st;
  wire        dt_wr  = wr & hit_dt;
  wire        dt_acc = (rd & hit_dt) | dt_wr;
  wire        seq_clr = arm_ff & dt_acc;
  wire [7:0]  status = {tc_ff, write_collision_flag_ff, slave_select_error_flag_ff, mode_fault_flag_ff, txe_ff, cfg_ff};
  reg  [7:0]  rmux;

  // read mux; unmapped addresses read as zero
  always @*
  begin
    if (hit_st)
      rmux = status;
    else if (hit_dt)
      rmux = rxdata_ff;
    else if (wb_adr_i == a_ctrl)
      rmux = ctrl_ff;
    else if (wb_adr_i == a_aux)
      rmux = {6'h00, aux_ff};
    else
      rmux = 8'h00;
  end

  // one wait state, so ack falls the cycle after it rose
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o)
        wb_dat_o <= {24'h000000, rmux};
    end
  end

  // ============================================================
  // registers and flags; a hardware set wins over any clear
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff   <= `SPSCR_RST_CTRL;
      aux_ff    <= `SPSCR_RST_AUX;
      {tc_ff, write_collision_flag_ff, slave_select_error_flag_ff, mode_fault_flag_ff, txe_ff, cfg_ff}
                <= `SPSCR_RST_STATUS;
      txbuf_ff  <= `SPSCR_RST_DATA;
      txfull_ff <= 1'b0;
      rxdata_ff <= `SPSCR_RST_DATA;
      arm_ff    <= 1'b0;
    end
    else
    begin
      if (wr & (wb_adr_i == a_ctrl))
        ctrl_ff <= wd;
      if (wr & (wb_adr_i == a_aux))
        aux_ff <= wd[1:0];
      if (st_wr)
        cfg_ff <= wd[2:0];
      // status read arms the read-then-data clear sequence
      if (rd & hit_st)
        arm_ff <= tc_ff | write_collision_flag_ff;
      else if (dt_acc)
        arm_ff <= 1'b0;
      // software write of zero clears a flag, a one leaves it
      if (done)
        tc_ff <= 1'b1;
      else if ((st_wr & ~wd[`SPSCR_ST_TC]) | seq_clr)
        tc_ff <= 1'b0;
      if (dt_wr & txfull_ff)
        write_collision_flag_ff <= 1'b1;
      else if ((st_wr & ~wd[`SPSCR_ST_WRITE_COLLISION_FLAG]) | seq_clr)
        write_collision_flag_ff <= 1'b0;
      if (slave_select_error_flag_ev)
        slave_select_error_flag_ff <= 1'b1;
      else if (st_wr & ~wd[`SPSCR_ST_SLAVE_SELECT_ERROR_FLAG])
        slave_select_error_flag_ff <= 1'b0;
      if (collide)
        mode_fault_flag_ff <= 1'b1;
      else if (st_wr & ~wd[`SPSCR_ST_MODE_FAULT_FLAG])
        mode_fault_flag_ff <= 1'b0;
      if (load)
        txe_ff <= 1'b1;
      else if (st_wr & ~wd[`SPSCR_ST_TXE])
        txe_ff <= 1'b0;
      // a write into a full buffer is dropped, the byte in flight goes on
      if (dt_wr & ~txfull_ff)
      begin
        txbuf_ff  <= wd;
        txfull_ff <= 1'b1;
      end
      else if (load)
        txfull_ff <= 1'b0;
      if (done)
        rxdata_ff <= rx_fin;
    end
  end

  // ============================================================
  // unit interrupt, registered so it never glitches
  always @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= uie & (tc_ff | mode_fault_flag_ff | (txe_ff & tx_buffer_irq_enable & enhanced_mode_bit));
  end

endmodule

/* File: verif/spscr_core_sva.sv */
// Purpose: port assertions for the spi unit
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every spscr_core instance
`timescale 1ns/1ps
module spscr_chk
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [3:0]  p1_oe_o,
  input wire        irq_o
);
  // ============================================================
  // bus answers and pin enables
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req  = wb_cyc_i && wb_stb_i;
  wire mapd = wb_adr_i[31:4] == 28'h31 && wb_adr_i[1:0] == 2'h0;
  a_ack_one_wait: assert property ($rose(req) |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_req: assert property (wb_ack_o |-> req && $past(req))
    else $error("ack without request");
  a_dat_high_zero: assert property (wb_dat_o[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_unmapped_zero: assert property
    (wb_ack_o && !wb_we_i && !mapd |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_dat_holds: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_oe_legal: assert property
    (p1_oe_o inside {4'h0, 4'hA, 4'h5, 4'h4, 4'h2})
    else $error("illegal pin enable pattern");
  // reset must leave the unit quiet, so no disable here
  a_quiet_reset: assert property (disable iff (1'b0)
    $fell(rst_i) |-> !irq_o && !wb_ack_o && p1_oe_o == 4'h0)
    else $error("outputs active after reset");
endmodule
bind spscr_core spscr_chk spscr_chk_i (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .p1_oe_o(p1_oe_o), .irq_o(irq_o));

/* File: verif/spscr_partner.sv */
// Purpose: slave device on the far side of the serial link
// Assumes: clock idle low, data caught on the rising edge
// Notes:   msb first; released miso shows the inverse of its last bit
`timescale 1ns/1ps
module spscr_partner
(
  input  wire       sck_i,
  input  wire       mosi_i,
  input  wire       sel_i,
  input  wire [7:0] tx_i,
  output wire       miso_o,
  output reg  [7:0] rx_o
);
  reg [7:0] sh_ff;
  reg       last_ff;
  // ============================================================
  // eight bits per frame, reply loaded when selected
  initial
  begin
    sh_ff = 8'h00;
    rx_o = 8'h00;
    last_ff = 1'b0;
  end
  always @(posedge sel_i) sh_ff = tx_i;
  always @(posedge sck_i)
    if (sel_i) rx_o = {rx_o[6:0], mosi_i};
  always @(negedge sck_i)
    if (sel_i)
    begin
      last_ff = sh_ff[7];
      sh_ff = {sh_ff[6:0], 1'b0};
    end
  // a released line must not look like valid data
  assign miso_o = sel_i ? sh_ff[7] : ~last_ff;
endmodule

/* File: verif/spscr_core_bench.sv */
// Purpose: self-checking bench for the spi unit
// Assumes: layout 0 during transfers, clock idle low, phase 0
// Notes:   a timer pulse every 5 cycles paces rate code 7
`timescale 1ns/1ps
module spscr_core_bench;
  reg         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, timer1_ovf_i;
  reg  [31:0] wb_adr_i, wb_dat_i, rnd;
  reg  [3:0]  wb_sel_i;
  reg  [7:0]  ptx, q, d, t;
  reg  [2:0]  tcnt, code;
  reg         ss_n, sel, ord, lay, bsck, bmosi;
  wire [31:0] wb_dat_o;
  wire        wb_ack_o, irq_o, miso;
  wire [3:0]  p1_o, p1_oe_o, pin, ext;
  wire [7:0]  prx;
  integer     bad_count, compares, cyc_n, i, n;
  // ============================================================
  // pin levels: the enabled driver wins, else the outside party
  assign ext = lay ? {ss_n, bsck, miso, bmosi} : {bsck, miso, bmosi, ss_n};
  assign pin = (p1_oe_o & p1_o) | (~p1_oe_o & ext);
  spscr_core spscr_core_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timer1_ovf_i(timer1_ovf_i),
    .p1_i(pin), .p1_o(p1_o), .p1_oe_o(p1_oe_o), .irq_o(irq_o));
  spscr_partner spscr_partner_i (.sck_i(pin[3]), .mosi_i(pin[1]),
    .sel_i(sel), .tx_i(ptx), .miso_o(miso), .rx_o(prx));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // ============================================================
  // timer pulse every fifth cycle; hang guard
  always @(posedge clk_i)
  begin
    tcnt <= (tcnt == 3'h4) ? 3'h0 : tcnt + 3'h1;
    timer1_ovf_i <= (tcnt == 3'h4);
    cyc_n = cyc_n + 1;
    if (cyc_n == 80000)
    begin
      bad_count = bad_count + 1;
      summarize;
    end
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function [7:0] rev(input [7:0] v, input o);
    rev = o ? {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]} : v;
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task summarize;
  begin
    $display("mismatches=%0d compares=%0d", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  // one classic cycle; held until ack is sampled high
  task wb(input [7:0] idx, input w, input [7:0] v);
    integer k;
  begin
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= {22'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, v};
    k = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 20)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    check(k < 20, 1);
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  end
  endtask
  task rd(input [7:0] idx, input [7:0] e);
  begin
    wb(idx, 1'b0, 8'h00);
    check(q, e);
  end
  endtask
  task wait_irq;
    integer k;
  begin
    k = 0;
    while (irq_o !== 1'b1 && k < 3000)
    begin
      @(posedge clk_i);
      k = k + 1;
    end
    check(k < 3000, 1);
  end
  endtask
  // bench as link master: clock idle low, data caught on the rising edge
  task sbyte(input [7:0] v, input [3:0] n);
    integer b;
  begin
    for (b = 0; b < n; b = b + 1)
    begin
      bmosi <= v[7 - b];
      repeat (8) @(posedge clk_i);
      q = {q[6:0], pin[2]};
      bsck <= 1'b1;
      repeat (8) @(posedge clk_i);
      bsck <= 1'b0;
    end
    repeat (8) @(posedge clk_i);
  end
  endtask
  // master setup: control first, enable afterwards
  task setup(input [2:0] c, input ig);
  begin
    wb(8'hC6, 1'b1, {c[2], 1'b0, ig, 3'b100, c[1:0]});
    wb(8'hC6, 1'b1, {c[2], 1'b1, ig, 3'b100, c[1:0]});
  end
  endtask
  // ============================================================
  // main sequence
  initial
  begin
    {rst_i, ss_n} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, timer1_ovf_i, sel, lay} = 6'h00;
    {bsck, bmosi} = 2'b00;
    {wb_adr_i, wb_dat_i, ptx, tcnt} = 0;
    wb_sel_i = 4'hF;
    {bad_count, compares, cyc_n} = 0;
    rnd = 32'hB29407E0;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'hC4, 8'h00);
    rd(8'hC5, 8'h00);
    rd(8'hC6, 8'h00);
    wb(8'h20, 1'b1, 8'hFF);
    rd(8'h20, 8'h00);
    wb(8'hC7, 1'b1, 8'h01);
    // random bytes, order and rate
    for (i = 0; i < 6; i = i + 1)
    begin
      rnd = lfsr(rnd);
      {ord, code, t, d} = {rnd[16], 3'h3 + {1'b0, rnd[18:17]}, rnd[15:0]};
      setup(code, 1'b1);
      wb(8'hC4, 1'b1, {5'h00, ord, 2'h0});
      ptx <= t;
      sel <= 1'b1;
      wb(8'hC5, 1'b1, d);
      wait_irq;
      rd(8'hC4, {5'h11, ord, 2'h0});
      check(prx, rev(d, ord));
      rd(8'hC5, rev(t, ord));
      rd(8'hC4, {5'h01, ord, 2'h0});
      check(irq_o, 1'b0);
      sel <= 1'b0;
    end
    // half period of the serial clock for every code
    for (i = 0; i < 8; i = i + 1)
    begin
      setup(i[2:0], 1'b1);
      wb(8'hC5, 1'b1, 8'hA5);
      n = 0;
      while (pin[3] !== 1'b1 && n < 2000)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      n = 0;
      while (pin[3] !== 1'b0 && n < 2000)
      begin
        @(posedge clk_i);
        n = n + 1;
      end
      check(n, i == 7 ? 5 : 1 << i);
      wait_irq;
      wb(8'hC4, 1'b1, 8'h00);
    end
    // collision on the select pin
    setup(3'h4, 1'b0);
    ss_n <= 1'b0;
    wait_irq;
    check(p1_oe_o, 4'h0);
    rd(8'hC4, 8'h10);
    wb(8'hC5, 1'b0, 8'h00);
    rd(8'hC4, 8'h10);
    ss_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    wb(8'hC4, 1'b1, 8'h00);
    rd(8'hC4, 8'h00);
    // third write hits a full buffer
    setup(3'h4, 1'b1);
    ptx <= 8'h3C;
    sel <= 1'b1;
    wb(8'hC5, 1'b1, 8'h5A);
    wb(8'hC5, 1'b1, 8'hC3);
    wb(8'hC5, 1'b1, 8'h99);
    wait_irq;
    check(prx, 8'h5A);
    rd(8'hC4, 8'hC8);
    rd(8'hC5, 8'h3C);
    rd(8'hC4, 8'h08);
    wait_irq;
    sel <= 1'b0;
    // empty-buffer interrupt gating
    wb(8'hC4, 1'b1, 8'h09);
    for (i = 0; i < 3; i = i + 1)
    begin
      if (i == 2) wb(8'hC4, 1'b1, 8'h08);
      wb(8'hC7, 1'b1, i == 1 ? 8'h01 : 8'h03);
      repeat (2) @(posedge clk_i);
      check(irq_o, i == 0);
    end
    wb(8'hC4, 1'b1, 8'h00);
    rd(8'hC4, 8'h00);
    // slave: an unloaded reply echoes the byte last received
    wb(8'hC6, 1'b1, 8'h00);
    wb(8'hC6, 1'b1, 8'h40);
    ss_n <= 1'b0;
    rnd = lfsr(rnd);
    sbyte(rnd[7:0], 4'h8);
    sbyte(8'h00, 4'h8);
    check(q, rnd[7:0]);
    rd(8'hC5, 8'h00);
    // select released after three bits
    sbyte(8'hFF, 4'h3);
    ss_n <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd(8'hC4, 8'hA0);
    wb(8'hC4, 1'b1, 8'h00);
    setup(3'h4, 1'b1);
    // pin layout and enable
    @(posedge clk_i);
    check(p1_oe_o, 4'hA);
    wb(8'hC4, 1'b1, 8'h02);
    lay <= 1'b1;
    @(posedge clk_i);
    check(p1_oe_o, 4'h5);
    wb(8'hC6, 1'b1, 8'hB0);
    @(posedge clk_i);
    check(p1_oe_o, 4'h0);
    summarize;
  end
endmodule
